// ### dv/pin_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// Loads on the timer channel pins
// ----------------------------------------
module pin_load #(
   parameter int N = 2
) (
   // Pin drive from the timer
   input  wire logic [N-1:0] pin_in,
   input  wire logic [N-1:0] oe_in,
   // Resolved wire level
   output logic [N-1:0]      level_out
);
   // Pull-up holds an undriven pin high, so a released pin never shows stale data
   assign level_out = (pin_in & oe_in) | ~oe_in;
endmodule : pin_load

// ### dv/timer_pwm_channel_update_bench.sv
`timescale 1ns/1ps
module timer_pwm_channel_update_bench;
   logic                               clk_in = 1'b0;
   logic                               rst_n_in = 1'b0;
   timer_pwm_pkg::cpu_acc_t            cpu = '0;
   logic [1:0]                         css = 2'h0;
   logic [2:0]                         pre = 3'h0;
   logic [15:0]                        modulo = 16'h0000;
   logic                               center = 1'b0;
   timer_pwm_pkg::ch_mode_t [1:0]      mode = '{timer_pwm_pkg::MODE_COMPARE,
                                                timer_pwm_pkg::MODE_COMPARE};
   logic [1:0]                         pol = 2'h0;
   logic                               halt = 1'b0;
   logic [7:0]                         rd_data;
   logic [15:0]                        cnt;
   logic                               per_end;
   logic [1:0]                         duty_evt;
   logic [1:0]                         pin;
   logic [1:0]                         oe;
   logic [1:0]                         level;
   int                                 mismatches = 0;
   int                                 n_checks = 0;
   integer                             seed = 70;
   logic [15:0]                        v;
   logic [15:0]                        r;
   logic [15:0]                        prev;
   logic                               up;

   always #25 clk_in = ~clk_in;

   timer_pwm_channel_update #(.NUM_CH(2)) u_dut (
      .clk_in                   (clk_in),
      .rst_n_in                 (rst_n_in),
      .cpu_in                   (cpu),
      .rd_data_out              (rd_data),
      .clock_source_select_in   (css),
      .prescale_sel_in          (pre),
      .counter_modulo_pair_in   (modulo),
      .center_aligned_pwm_in    (center),
      .ch_mode_in               (mode),
      .active_low_in            (pol),
      .debug_halt_mode_in       (halt),
      .timer_count_value_out    (cnt),
      .period_end_out           (per_end),
      .duty_event_out           (duty_evt),
      .timer_channel_pin_out    (pin),
      .timer_channel_pin_oe_out (oe)
   );

   pin_load #(.N(2)) u_load (
      .pin_in    (pin),
      .oe_in     (oe),
      .level_out (level)
   );

   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   // Caller stands at a falling edge; the access is held for one full cycle
   task automatic acc(input logic w, input timer_pwm_pkg::acc_t s, input logic [2:0] c,
                      input logic [7:0] d);
      cpu.wr   = w;
      cpu.rd   = ~w;
      cpu.sel  = s;
      cpu.ch   = c;
      cpu.data = d;
      @(negedge clk_in);
   endtask : acc

   task automatic idle();
      cpu = '0;
      @(negedge clk_in);
   endtask : idle

   task automatic wr16(input logic [2:0] c, input logic [15:0] d, input logic lo_first);
      if (lo_first)
      begin
         acc(1'b1, timer_pwm_pkg::ACC_CH_VL, c, d[7:0]);
         acc(1'b1, timer_pwm_pkg::ACC_CH_VH, c, d[15:8]);
      end
      else
      begin
         acc(1'b1, timer_pwm_pkg::ACC_CH_VH, c, d[15:8]);
         acc(1'b1, timer_pwm_pkg::ACC_CH_VL, c, d[7:0]);
      end
      idle();
   endtask : wr16

   task automatic rd16(input logic [2:0] c, output logic [15:0] q);
      acc(1'b0, timer_pwm_pkg::ACC_CH_VH, c, 8'h00);
      q[15:8] = rd_data;
      acc(1'b0, timer_pwm_pkg::ACC_CH_VL, c, 8'h00);
      q[7:0] = rd_data;
      idle();
   endtask : rd16

   task automatic clr_cnt();
      acc(1'b1, timer_pwm_pkg::ACC_CNT_L, 3'h0, 8'($random(seed)));
      idle();
   endtask : clr_cnt

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   function automatic logic [15:0] edge_next(input logic [15:0] c, input logic [15:0] top);
      return (c == top) ? 16'h0000 : c + 16'h0001;
   endfunction : edge_next

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial
   begin
      #(50 * 5000);
      mismatches++;
      final_report();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      chk(cnt, 16'h0000);
      chk({14'h0, per_end, pin[0]}, 16'h0000);
      // Clock off: word lands on second byte, either order
      for (int i = 0; i < 4; i++)
      begin
         v = 16'($random(seed));
         wr16(3'h0, v, i[0]);
         rd16(3'h0, r);
         chk(r, v);
      end
      // Status write restarts the byte pairing
      wr16(3'h0, 16'h1234, 1'b0);
      acc(1'b1, timer_pwm_pkg::ACC_CH_VH, 3'h0, 8'hAB);
      acc(1'b1, timer_pwm_pkg::ACC_CH_SC, 3'h0, 8'h00);
      acc(1'b1, timer_pwm_pkg::ACC_CH_VL, 3'h0, 8'hCD);
      idle();
      rd16(3'h0, r);
      chk(r, 16'h1234);
      acc(1'b1, timer_pwm_pkg::ACC_CH_VH, 3'h0, 8'h56);
      idle();
      rd16(3'h0, r);
      chk(r, 16'h56CD);
      // Capture channel refuses value writes and releases its pin
      mode[1] = timer_pwm_pkg::MODE_CAPTURE;
      wr16(3'h1, 16'($random(seed)), 1'b0);
      rd16(3'h1, r);
      chk(r, 16'h0000);
      chk({14'h0, oe}, 16'h0001);
      chk({14'h0, level}, {14'h0, 1'b1, pin[0]});
      // Halt: direct single-byte write, pre-halt byte completes afterwards
      wr16(3'h0, 16'h1234, 1'b0);
      acc(1'b1, timer_pwm_pkg::ACC_CH_VH, 3'h0, 8'hAA);
      idle();
      halt = 1'b1;
      acc(1'b1, timer_pwm_pkg::ACC_CH_VH, 3'h0, 8'h77);
      idle();
      rd16(3'h0, r);
      chk(r, 16'h7734);
      halt = 1'b0;
      acc(1'b1, timer_pwm_pkg::ACC_CH_VL, 3'h0, 8'h55);
      idle();
      rd16(3'h0, r);
      chk(r, 16'hAA55);
      // Free-running moduli, count reads in between
      css = 2'h1;
      for (int k = 0; k < 2; k++)
      begin
         modulo = k[0] ? 16'hFFFF : 16'h0000;
         clr_cnt();
         chk(cnt, 16'h0001);
         for (int j = 0; j < 19; j++)
         begin
            if (k[0])
               acc(1'b0, timer_pwm_pkg::ACC_CNT_L, 3'h0, 8'h00);
            else
               acc(1'b0, timer_pwm_pkg::ACC_CNT_H, 3'h0, 8'h00);
         end
         chk(cnt, 16'h0014);
         chk({8'h00, rd_data}, k[0] ? 16'h0013 : 16'h0000);
         idle();
      end
      // Edge-aligned walk, modulo 3
      modulo = 16'h0003;
      clr_cnt();
      for (int i = 0; i < 10; i++)
      begin
         prev = cnt;
         @(negedge clk_in);
         chk(cnt, edge_next(prev, 16'h0003));
         chk({15'h0, per_end}, {15'h0, (prev == 16'h0003)});
      end
      // Center-aligned walk, modulo 3
      center = 1'b1;
      clr_cnt();
      up = 1'b1;
      for (int i = 0; i < 14; i++)
      begin
         prev = cnt;
         if (prev == 16'h0003)
            up = 1'b0;
         if (prev == 16'h0000)
            up = 1'b1;
         @(negedge clk_in);
         chk(cnt, up ? prev + 16'h0001 : prev - 16'h0001);
         chk({15'h0, per_end}, {15'h0, (prev == 16'h0000)});
      end
      // Edge PWM commit waits for the step into the modulo value
      center = 1'b0;
      mode[0] = timer_pwm_pkg::MODE_EDGE_PWM;
      modulo = 16'h0028;
      clr_cnt();
      wr16(3'h0, 16'h0123, 1'b0);
      rd16(3'h0, r);
      chk(r, 16'hAA55);
      repeat (45) @(negedge clk_in);
      rd16(3'h0, r);
      chk(r, 16'h0123);
      // Edge PWM pin and duty event, both polarities
      wr16(3'h0, 16'h0005, 1'b1);
      repeat (45) @(negedge clk_in);
      for (int i = 0; i < 90; i++)
      begin
         pol = {1'b0, i >= 45};
         @(negedge clk_in);
         v = {14'h0, pol[0] ^ (cnt < 16'h0005), cnt == 16'h0005};
         chk({14'h0, pin[0], duty_evt[0]}, v);
      end
      // Center PWM: down match raises the pin, up match drops it
      pol = 2'h0;
      center = 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         prev = cnt;
         @(negedge clk_in);
         if (prev == 16'h0005)
            chk({15'h0, pin[0]}, {15'h0, cnt < prev});
      end
      // Compare mode commits on the next counter tick
      center = 1'b0;
      mode[0] = timer_pwm_pkg::MODE_COMPARE;
      pre = 3'h2;
      v = 16'($random(seed));
      wr16(3'h0, v, 1'b0);
      repeat (4) @(negedge clk_in);
      rd16(3'h0, r);
      chk(r, v);
      final_report();
   end
endmodule : timer_pwm_channel_update_bench

// ### hdl/timer_pwm_channel_update.sv
// Function
// [RULE_01] Edge PWM period is modulo plus one
// [RULE_02] Channel value sets duty; polarity selectable
// [RULE_03] Events at period end and duty transition
// [RULE_04] Center PWM period twice modulo value
// [RULE_05] Center mode counts up to modulo, down
// [RULE_06] Down match activates, up match deactivates
// [RULE_07] One pin per channel, one to eight
// [RULE_08] Modulo zero or all-ones means free-running
// [RULE_09] Reading count never disturbs counting
// [RULE_10] Any count byte write clears counter
// [RULE_11] Capture mode ignores channel value writes; code accepts them while center-aligned PWM is on
// [RULE_12] Status write releases read latch always
// [RULE_13] Halt freezes read latch despite reads
// [RULE_14] Halt reads return real register bytes
// [RULE_15] Value bytes buffered, committed as word
// [RULE_16] Clock off: commit on second byte
// [RULE_17] Compare mode: commit on next tick
// [RULE_18] PWM: commit at modulo-1 to modulo
// [RULE_19] Status write resets write buffering
// [RULE_20] Bytes accepted in either order
// [RULE_21] Halt writes go direct, buffer frozen
// [RULE_22] Pending pre-halt sequence completes later
// [RULE_23] System supplies synchronous halt level
`timescale 1ns/1ps
module timer_pwm_channel_update #(
   parameter int NUM_CH = 2
) (
   // Clock and reset
   input  wire logic                                   clk_in,
   input  wire logic                                   rst_n_in,
   // CPU byte access
   input  wire timer_pwm_pkg::cpu_acc_t                cpu_in,
   output logic [7:0]                                  rd_data_out,
   // Configuration
   input  wire logic [1:0]                             clock_source_select_in,
   input  wire logic [2:0]                             prescale_sel_in,
   input  wire logic [15:0]                            counter_modulo_pair_in,
   input  wire logic                                   center_aligned_pwm_in,
   input  wire timer_pwm_pkg::ch_mode_t [NUM_CH-1:0]   ch_mode_in,
   input  wire logic [NUM_CH-1:0]                      active_low_in,
   input  wire logic                                   debug_halt_mode_in,
   // Status and events
   output logic [15:0]                                 timer_count_value_out,
   output logic                                        period_end_out,
   output logic [NUM_CH-1:0]                           duty_event_out,
   // Channel pins
   output logic [NUM_CH-1:0]                           timer_channel_pin_out,
   output logic [NUM_CH-1:0]                           timer_channel_pin_oe_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0]                          cnt;
      logic                                 down;
      logic [6:0]                           pre;
      logic                                 period_end;
      logic [7:0]                           rd_data;
      timer_pwm_pkg::chan_t [NUM_CH-1:0]    ch;
   } state_t;

   state_t      s_r;
   state_t      s_nxt;
   logic        clk_on;
   logic        tick;
   logic        free_run;
   logic [15:0] top;
   logic        pwm_commit;

   function automatic logic pre_done(input logic [6:0] pre, input logic [2:0] sel);
      logic [6:0] mask;
      mask = 7'((timer_pwm_pkg::MASK_ONE << sel) - timer_pwm_pkg::MASK_ONE);
      return (pre & mask) == mask;
   endfunction : pre_done

   function automatic logic is_pwm(input timer_pwm_pkg::ch_mode_t m, input logic ctr);
      return ctr || (m == timer_pwm_pkg::MODE_EDGE_PWM);
   endfunction : is_pwm

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      timer_pwm_pkg::chan_t c;
      logic                 hit;
      logic                 pwm;
      c            = '0;
      hit          = 1'b0;
      pwm          = 1'b0;
      s_nxt        = s_r;
      s_nxt.period_end = 1'b0;
      free_run     = (counter_modulo_pair_in == timer_pwm_pkg::CNT_ZERO) ||
                     (counter_modulo_pair_in == timer_pwm_pkg::CNT_FULL); // RULE_08
      top          = free_run ? timer_pwm_pkg::CNT_FULL : counter_modulo_pair_in;
      clk_on       = clock_source_select_in != timer_pwm_pkg::CLK_OFF;
      tick         = clk_on && pre_done(s_r.pre, prescale_sel_in);
      // Covers FFFE->FFFF when free-running since top is all ones then
      pwm_commit   = tick && !s_r.down && (s_r.cnt == 16'(top - timer_pwm_pkg::CNT_ONE)); // RULE_18

      if (clk_on)
      begin
         s_nxt.pre = tick ? timer_pwm_pkg::PRE_ZERO : 7'(s_r.pre + timer_pwm_pkg::PRE_ONE);
      end

      // ----------------------------------------
      // Counter
      // ----------------------------------------
      if (tick)
      begin
         if (center_aligned_pwm_in)
         begin
            if (!s_r.down)
            begin
               if (s_r.cnt >= top)
               begin
                  s_nxt.down = 1'b1; // RULE_05
                  s_nxt.cnt  = 16'(s_r.cnt - timer_pwm_pkg::CNT_ONE); // RULE_04
               end
               else
               begin
                  s_nxt.cnt = 16'(s_r.cnt + timer_pwm_pkg::CNT_ONE);
               end
            end
            else if (s_r.cnt == timer_pwm_pkg::CNT_ZERO)
            begin
               s_nxt.down       = 1'b0;
               s_nxt.cnt        = timer_pwm_pkg::CNT_ONE;
               s_nxt.period_end = 1'b1;
            end
            else
            begin
               s_nxt.cnt = 16'(s_r.cnt - timer_pwm_pkg::CNT_ONE);
            end
         end
         else if (s_r.cnt >= top)
         begin
            s_nxt.cnt        = timer_pwm_pkg::CNT_ZERO; // RULE_01
            s_nxt.down       = 1'b0;
            s_nxt.period_end = 1'b1; // RULE_03
         end
         else
         begin
            s_nxt.cnt  = 16'(s_r.cnt + timer_pwm_pkg::CNT_ONE);
            s_nxt.down = 1'b0;
         end
      end

      // Count reads only copy the value out
      if (cpu_in.rd && cpu_in.sel == timer_pwm_pkg::ACC_CNT_H)
      begin
         s_nxt.rd_data = s_r.cnt[15:8]; // RULE_09
      end
      if (cpu_in.rd && cpu_in.sel == timer_pwm_pkg::ACC_CNT_L)
      begin
         s_nxt.rd_data = s_r.cnt[7:0]; // RULE_09
      end
      if (cpu_in.wr && (cpu_in.sel == timer_pwm_pkg::ACC_CNT_H ||
                        cpu_in.sel == timer_pwm_pkg::ACC_CNT_L))
      begin
         s_nxt.cnt  = timer_pwm_pkg::CNT_ZERO; // RULE_10
         s_nxt.pre  = timer_pwm_pkg::PRE_ZERO;
         s_nxt.down = 1'b0;
      end

      // ----------------------------------------
      // Channels
      // ----------------------------------------
      for (int i = 0; i < NUM_CH; i++)
      begin
         c   = s_r.ch[i];
         hit = cpu_in.ch == 3'(i);
         pwm = is_pwm(ch_mode_in[i], center_aligned_pwm_in);
         c.duty_evt = 1'b0;
         c.oe       = center_aligned_pwm_in ||
                      (ch_mode_in[i] != timer_pwm_pkg::MODE_CAPTURE); // RULE_07

         // Buffer frozen during halt, so a pending word waits for resume
         if (c.pend && !debug_halt_mode_in)
         begin
            if ((pwm && pwm_commit) || (!pwm && tick))
            begin
               c.val  = {c.wbuf_hi, c.wbuf_lo}; // RULE_17 RULE_22
               c.pend = 1'b0;
            end
         end

         // Output generation uses the committed value
         if (tick && center_aligned_pwm_in)
         begin
            if (s_r.cnt == c.val)
            begin
               c.pin      = active_low_in[i] ^ s_r.down; // RULE_06
               c.duty_evt = 1'b1;
            end
         end
         else if (tick && pwm)
         begin
            c.pin      = active_low_in[i] ^ (s_nxt.cnt < c.val); // RULE_02
            c.duty_evt = s_nxt.cnt == c.val; // RULE_03
         end
         else if (tick && ch_mode_in[i] == timer_pwm_pkg::MODE_COMPARE &&
                  s_r.cnt == c.val)
         begin
            c.pin      = !c.pin;
            c.duty_evt = 1'b1;
         end

         if (cpu_in.wr && hit && cpu_in.sel == timer_pwm_pkg::ACC_CH_SC)
         begin
            c.got_hi  = 1'b0; // RULE_19
            c.got_lo  = 1'b0;
            c.pend    = 1'b0;
            c.rd_held = 1'b0; // RULE_12
         end

         if (cpu_in.wr && hit && c.oe &&
             (cpu_in.sel == timer_pwm_pkg::ACC_CH_VH ||
              cpu_in.sel == timer_pwm_pkg::ACC_CH_VL)) // RULE_11
         begin
            if (debug_halt_mode_in)
            begin
               if (cpu_in.sel == timer_pwm_pkg::ACC_CH_VH)
               begin
                  c.val[15:8] = cpu_in.data; // RULE_21
               end
               else
               begin
                  c.val[7:0] = cpu_in.data; // RULE_21
               end
            end
            else
            begin
               if (cpu_in.sel == timer_pwm_pkg::ACC_CH_VH)
               begin
                  c.wbuf_hi = cpu_in.data; // RULE_15
                  c.got_hi  = 1'b1;
               end
               else
               begin
                  c.wbuf_lo = cpu_in.data; // RULE_15
                  c.got_lo  = 1'b1;
               end
               if (c.got_hi && c.got_lo)
               begin
                  c.got_hi = 1'b0; // RULE_20
                  c.got_lo = 1'b0;
                  if (!clk_on)
                  begin
                     c.val  = {c.wbuf_hi, c.wbuf_lo}; // RULE_16
                     c.pend = 1'b0;
                  end
                  else
                  begin
                     c.pend = 1'b1;
                  end
               end
            end
         end

         if (cpu_in.rd && hit && cpu_in.sel == timer_pwm_pkg::ACC_CH_VH)
         begin
            s_nxt.rd_data = s_r.ch[i].val[15:8]; // RULE_14
            if (!debug_halt_mode_in)
            begin
               c.rd_lo   = s_r.ch[i].val[7:0];
               c.rd_held = 1'b1;
            end
         end
         if (cpu_in.rd && hit && cpu_in.sel == timer_pwm_pkg::ACC_CH_VL)
         begin
            if (debug_halt_mode_in)
            begin
               s_nxt.rd_data = s_r.ch[i].val[7:0]; // RULE_13 RULE_14
            end
            else
            begin
               s_nxt.rd_data = c.rd_held ? c.rd_lo : s_r.ch[i].val[7:0];
               c.rd_held     = 1'b0;
            end
         end
         s_nxt.ch[i] = c;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb
   begin
      rd_data_out           = s_r.rd_data;
      timer_count_value_out = s_r.cnt;
      period_end_out        = s_r.period_end;
      for (int i = 0; i < NUM_CH; i++)
      begin
         duty_event_out[i]           = s_r.ch[i].duty_evt;
         timer_channel_pin_out[i]    = s_r.ch[i].pin;
         timer_channel_pin_oe_out[i] = s_r.ch[i].oe;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_cnt_write_clear: assert property ( // RULE_10
      cpu_in.wr && (cpu_in.sel == timer_pwm_pkg::ACC_CNT_H ||
                    cpu_in.sel == timer_pwm_pkg::ACC_CNT_L) |=> s_r.cnt == 16'h0000)
      else $error("count write did not clear counter");
   a_cnt_read_quiet: assert property ( // RULE_09
      cpu_in.rd && !cpu_in.wr && !tick |=> s_r.cnt == $past(s_r.cnt))
      else $error("count read disturbed counting");
   a_edge_wrap: assert property ( // RULE_01
      tick && !center_aligned_pwm_in && s_r.cnt == top && !cpu_in.wr
      |=> s_r.cnt == 16'h0000 && s_r.period_end)
      else $error("edge period wrap wrong");
   a_free_top: assert property ( // RULE_08
      tick && free_run && !center_aligned_pwm_in && s_r.cnt == 16'hFFFE && !cpu_in.wr
      |=> s_r.cnt == 16'hFFFF)
      else $error("free-running counter did not reach all ones");
   a_center_turn: assert property ( // RULE_05
      tick && center_aligned_pwm_in && !s_r.down && s_r.cnt == top &&
      top > 16'h0001 && !cpu_in.wr |=> s_r.down ##1 s_r.down)
      else $error("center counter did not turn down");
   a_capture_ignore: assert property ( // RULE_11
      cpu_in.wr && cpu_in.ch == 3'(NUM_CH - 1) && !center_aligned_pwm_in &&
      ch_mode_in[NUM_CH-1] == timer_pwm_pkg::MODE_CAPTURE && !s_r.ch[NUM_CH-1].pend
      |=> $stable(s_r.ch[NUM_CH-1].val))
      else $error("capture channel took a value write");
   a_sc_release: assert property ( // RULE_19
      cpu_in.wr && cpu_in.ch == 3'h0 && cpu_in.sel == timer_pwm_pkg::ACC_CH_SC
      |=> !s_r.ch[0].got_hi && !s_r.ch[0].got_lo && !s_r.ch[0].pend)
      else $error("status write left buffering armed");
   a_sc_unlatch: assert property ( // RULE_12
      cpu_in.wr && cpu_in.ch == 3'h0 && cpu_in.sel == timer_pwm_pkg::ACC_CH_SC
      |=> !s_r.ch[0].rd_held)
      else $error("status write left read latch held");
   a_halt_direct: assert property ( // RULE_21
      debug_halt_mode_in && cpu_in.wr && cpu_in.ch == 3'h0 && s_r.ch[0].oe &&
      cpu_in.sel == timer_pwm_pkg::ACC_CH_VH
      |=> s_r.ch[0].val[15:8] == $past(cpu_in.data) && $stable(s_r.ch[0].got_lo))
      else $error("halt write did not bypass buffer");
   a_halt_read: assert property ( // RULE_14
      debug_halt_mode_in && cpu_in.rd && cpu_in.ch == 3'h0 &&
      cpu_in.sel == timer_pwm_pkg::ACC_CH_VL |=> s_r.rd_data == $past(s_r.ch[0].val[7:0]))
      else $error("halt read returned buffer");
   a_pwm_hold: assert property ( // RULE_18
      s_r.ch[0].pend && clk_on && !debug_halt_mode_in && !pwm_commit && !cpu_in.wr &&
      is_pwm(ch_mode_in[0], center_aligned_pwm_in) |=> $stable(s_r.ch[0].val))
      else $error("pwm value committed off the boundary");

   c_pwm_commit: cover property (s_r.ch[0].pend && pwm_commit ##1 !s_r.ch[0].pend);
   c_center_cycle: cover property (center_aligned_pwm_in && s_r.period_end);
   c_halt_write: cover property (debug_halt_mode_in && cpu_in.wr && s_r.ch[0].got_hi);

endmodule : timer_pwm_channel_update

// ### hdl/timer_pwm_pkg.sv
package timer_pwm_pkg;

   // ----------------------------------------
   // Counter constants
   // ----------------------------------------
   localparam int          CNT_W       = 16;
   localparam logic [15:0] CNT_ZERO    = 16'h0000;
   localparam logic [15:0] CNT_ONE     = 16'h0001;
   localparam logic [15:0] CNT_FULL    = 16'hFFFF;
   localparam logic [1:0]  CLK_OFF     = 2'h0;
   localparam int          PRE_W       = 7;
   localparam logic [6:0]  PRE_ZERO    = 7'h00;
   localparam logic [6:0]  PRE_ONE     = 7'h01;
   localparam logic [7:0]  MASK_ONE    = 8'h01;
   localparam int          CH_MAX      = 8;

   // ----------------------------------------
   // Byte access selector and channel modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      ACC_NONE,
      ACC_CNT_H,
      ACC_CNT_L,
      ACC_CH_SC,
      ACC_CH_VH,
      ACC_CH_VL
   } acc_t;

   typedef enum logic [1:0] {
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_EDGE_PWM
   } ch_mode_t;

   // One byte-wide CPU access per cycle
   typedef struct packed {
      logic       wr;
      logic       rd;
      acc_t       sel;
      logic [2:0] ch;
      logic [7:0] data;
   } cpu_acc_t;

   // Per-channel state
   typedef struct packed {
      logic [15:0] val;
      logic [7:0]  wbuf_hi;
      logic [7:0]  wbuf_lo;
      logic        got_hi;
      logic        got_lo;
      logic        pend;
      logic        rd_held;
      logic [7:0]  rd_lo;
      logic        pin;
      logic        oe;
      logic        duty_evt;
   } chan_t;

endpackage : timer_pwm_pkg
